/* hdl/bcc_pkg.sv */
/*
  Constants shared by the block check calculator.
  Assumes a single system clock; no software-visible registers.
*/
package bcc_pkg;
  localparam logic [1:0]  FORM_ADD     = 2'h0;
  localparam logic [1:0]  FORM_LRC     = 2'h1;
  localparam logic [1:0]  FORM_CRC     = 2'h2;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;
  localparam logic [3:0]  CRC_SHIFTS   = 4'h8;
  localparam logic [7:0]  ASCII_ZERO   = 8'h30;
  localparam logic [7:0]  ASCII_LETTER = 8'h37;
  localparam logic [7:0]  ASCII_A      = 8'h41;
  localparam logic [3:0]  NIBBLE_TEN   = 4'ha;
  localparam logic [2:0]  DIGITS_MAX   = 3'h4;
  localparam logic [1:0]  PORT_SEND1   = 2'h0;
  localparam logic [1:0]  PORT_SEND2   = 2'h1;
  localparam logic [1:0]  PORT_RECV1   = 2'h2;
  localparam logic [1:0]  PORT_RECV2   = 2'h3;
endpackage

/* hdl/bcc_crc_step.sv */
/*
  One CRC-16 byte round: eight right shifts with reflected polynomial.
  Assumes the caller already folded the message byte into the register.
*/
`timescale 1ns/1ps
module bcc_crc_step (
  input  wire logic [15:0] i_crc,
  output logic      [15:0] o_crc
);
  logic [15:0] stage [0:8];
  assign stage[0] = i_crc;
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_shift
      // Carry out of bit zero selects the polynomial fold
      assign stage[k+1] = stage[k][0] ? ((stage[k] >> 1) ^ bcc_pkg::CRC_POLY)
                                      : (stage[k] >> 1);
    end
  endgenerate
  assign o_crc = stage[8];
endmodule

/* hdl/block_check_calculator.sv */
/*
  Block check calculator for the serial send/receive instruction logic.
  Assumes the caller streams covered bytes (start position up to the byte
  before the check field) with i_BYTE_VALID, then pulses i_END. On receive
  the received check field bytes are given on i_RX_CHECK before i_END.
*/
`timescale 1ns/1ps
// Operation
// - Additive sum over range, then two's complement
// - Additive result placed raw or ASCII, digit count
// - LRC pairs ASCII hex into one byte
// - LRC sums pair bytes, then two's complement
// - LRC low byte emitted as two ASCII
// - CRC starts with FFFF xor first byte
// - Eight right shifts, fold A001 on carry
// - Xor next byte, repeat through range end
// - CRC bytes swapped, low byte first
// - All formulas on both send and receive ports
module block_check_calculator (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        i_START,
  input  wire logic [1:0]  i_PORT_OP,
  input  wire logic [1:0]  i_FORMULA,
  input  wire logic        i_ASCII_CONV,
  input  wire logic [2:0]  i_DIGITS,
  input  wire logic        i_BYTE_VALID,
  input  wire logic [7:0]  i_BYTE,
  input  wire logic        i_END,
  input  wire logic [31:0] i_RX_CHECK,
  output logic      [31:0] o_CHECK,
  output logic      [2:0]  o_CHECK_LEN,
  output logic             o_DONE,
  output logic             o_MISMATCH,
  output logic             o_BUSY,
  output logic      [1:0]  o_PORT_OP
);
  typedef enum {ST_IDLE, ST_RUN} state_e;
  state_e      state;
  logic [1:0]  formula;
  logic        ascii_conv;
  logic [2:0]  digits;
  logic        is_recv;
  logic [15:0] sum;
  logic [15:0] crc;
  logic        crc_first;
  logic [3:0]  hi_nib;
  logic        half;

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    // Non-hex characters below 41h contribute their low nibble, others the low nibble of c minus 37h; limitation accepted
    hex_val = (c >= bcc_pkg::ASCII_A) ? 4'(c - bcc_pkg::ASCII_LETTER) : c[3:0];
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < bcc_pkg::NIBBLE_TEN) ? (bcc_pkg::ASCII_ZERO + {4'h0, n})
                                        : (bcc_pkg::ASCII_LETTER + {4'h0, n});
  endfunction

  wire         run_byte  = (state == ST_RUN) && i_BYTE_VALID;
  wire  [7:0]  pair_byte = {hi_nib, hex_val(i_BYTE)};
  wire  [15:0] crc_in    = crc_first ? (bcc_pkg::CRC_INIT ^ {8'h00, i_BYTE})
                                     : (crc ^ {8'h00, i_BYTE});
  wire  [15:0] crc_next;
  wire  [15:0] add_neg   = 16'(~sum + 16'h0001);
  wire  [7:0]  lrc_neg   = 8'(~sum[7:0] + 8'h01);
  wire  [15:0] crc_swap  = {crc[7:0], crc[15:8]};
  wire  [31:0] add_ascii = {hex_chr(add_neg[15:12]), hex_chr(add_neg[11:8]),
                            hex_chr(add_neg[7:4]), hex_chr(add_neg[3:0])};
  wire  [2:0]  add_dig   = (digits > bcc_pkg::DIGITS_MAX) ? bcc_pkg::DIGITS_MAX
                         : (digits == 3'h0) ? 3'h1 : digits;
  // Keep the lowest digits, packed at the bottom, first char highest
  wire  [31:0] add_mask  = 32'hffffffff >> (6'(bcc_pkg::DIGITS_MAX - add_dig) * 6'h08);
  wire  [2:0]  add_bytes = (add_dig > 3'h2) ? 3'h2 : 3'h1;
  wire  [31:0] add_raw_m = 32'hffffffff >> (6'(bcc_pkg::DIGITS_MAX - add_bytes) * 6'h08);
  wire  [31:0] add_out   = ascii_conv ? (add_ascii & add_mask)
                                      : ({16'h0000, add_neg} & add_raw_m);
  wire  [2:0]  add_len   = ascii_conv ? add_dig : add_bytes;
  wire  [31:0] lrc_out   = {16'h0000, hex_chr(lrc_neg[7:4]), hex_chr(lrc_neg[3:0])};
  wire  [31:0] next_check = (formula == bcc_pkg::FORM_LRC) ? lrc_out
                          : (formula == bcc_pkg::FORM_CRC) ? {16'h0000, crc_swap}
                          : add_out;
  // Code 3 falls back to the additive path, so its length must follow too
  wire  [2:0]  next_len  = (formula == bcc_pkg::FORM_LRC || formula == bcc_pkg::FORM_CRC) ? 3'h2
                         : add_len;
  wire  [31:0] len_mask  = 32'hffffffff >> (6'(bcc_pkg::DIGITS_MAX - next_len) * 6'h08);
  wire         finish    = (state == ST_RUN) && i_END;
  wire         differ    = (next_check & len_mask) != (i_RX_CHECK & len_mask);

  bcc_crc_step u_crc (
    .i_crc (crc_in),
    .o_crc (crc_next)
  );

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= i_START ? ST_RUN : ST_IDLE;
        ST_RUN:  state <= i_END ? ST_IDLE : ST_RUN;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Setup is latched at start so any port/formula pair is accepted
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      formula    <= bcc_pkg::FORM_ADD;
      ascii_conv <= 1'b0;
      digits     <= 3'h0;
      is_recv    <= 1'b0;
      o_PORT_OP  <= bcc_pkg::PORT_SEND1;
    end else if (state == ST_IDLE && i_START) begin
      formula    <= i_FORMULA;
      ascii_conv <= i_ASCII_CONV;
      digits     <= i_DIGITS;
      is_recv    <= i_PORT_OP[1];
      o_PORT_OP  <= i_PORT_OP;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sum       <= 16'h0000;
      crc       <= bcc_pkg::CRC_INIT;
      crc_first <= 1'b1;
      hi_nib    <= 4'h0;
      half      <= 1'b0;
    end else if (state == ST_IDLE && i_START) begin
      sum       <= 16'h0000;
      crc       <= bcc_pkg::CRC_INIT;
      crc_first <= 1'b1;
      half      <= 1'b0;
    end else if (run_byte) begin
      case (formula)
        bcc_pkg::FORM_LRC: begin
          // An odd trailing character is dropped, never half-added
          if (half) begin
            sum <= 16'(sum + {8'h00, pair_byte});
          end else begin
            hi_nib <= hex_val(i_BYTE);
          end
          half <= ~half;
        end
        bcc_pkg::FORM_CRC: begin
          crc       <= crc_next;
          crc_first <= 1'b0;
        end
        default: sum <= 16'(sum + {8'h00, i_BYTE});
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      o_CHECK     <= 32'h00000000;
      o_CHECK_LEN <= 3'h0;
      o_DONE      <= 1'b0;
      o_MISMATCH  <= 1'b0;
    end else begin
      o_DONE <= finish;
      if (finish) begin
        o_CHECK     <= next_check;
        o_CHECK_LEN <= next_len;
        o_MISMATCH  <= is_recv && differ;
      end else if (state == ST_IDLE && i_START) begin
        o_MISMATCH  <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      o_BUSY <= 1'b0;
    end else begin
      o_BUSY <= (state == ST_IDLE) ? i_START : !i_END;
    end
  end

  property p_crc_swap;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula == bcc_pkg::FORM_CRC |=>
        o_CHECK[15:0] == {$past(crc[7:0]), $past(crc[15:8])} && o_CHECK_LEN == 3'h2;
  endproperty
  a_crc_swap: assert property (p_crc_swap) else $error("CRC bytes not swapped");

  property p_crc_init;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && crc_first && formula == bcc_pkg::FORM_CRC |=> !crc_first;
  endproperty
  a_crc_init: assert property (p_crc_init) else $error("CRC first flag stuck");

  property p_add_sum;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && formula == bcc_pkg::FORM_ADD |=>
        sum == 16'($past(sum) + {8'h00, $past(i_BYTE)});
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("Sum not accumulated");

  property p_lrc_len;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula == bcc_pkg::FORM_LRC |=> o_CHECK_LEN == 3'h2 && o_CHECK[31:16] == 16'h0;
  endproperty
  a_lrc_len: assert property (p_lrc_len) else $error("LRC not two chars");

  property p_mismatch_send;
    @(posedge I_MCLK) disable iff (I_RST)
      o_DONE && !o_PORT_OP[1] |-> !o_MISMATCH;
  endproperty
  a_mismatch_send: assert property (p_mismatch_send) else $error("Mismatch on send");

  property p_done_pulse;
    @(posedge I_MCLK) disable iff (I_RST)
      o_DONE |=> !o_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("Done not a pulse");

  property p_lrc_half;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && formula == bcc_pkg::FORM_LRC && !half |=> $stable(sum) && half;
  endproperty
  a_lrc_half: assert property (p_lrc_half) else $error("LRC pair broken");

  property p_ascii_chars;
    @(posedge I_MCLK) disable iff (I_RST)
      o_DONE && o_CHECK_LEN == 3'h2 && $past(formula) == bcc_pkg::FORM_LRC |->
        (o_CHECK[7:0] inside {[8'h30:8'h39], [8'h41:8'h46]});
  endproperty
  a_ascii_chars: assert property (p_ascii_chars) else $error("Bad hex char");

  property p_busy_start;
    @(posedge I_MCLK) disable iff (I_RST)
      state == ST_IDLE && i_START |=> o_BUSY;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("Busy not raised");

  property p_busy_end;
    @(posedge I_MCLK) disable iff (I_RST)
      finish |=> !o_BUSY;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("Busy not dropped");

  property p_done_end;
    @(posedge I_MCLK) disable iff (I_RST)
      finish |=> o_DONE;
  endproperty
  a_done_end: assert property (p_done_end) else $error("Done missing");

  property p_done_only_end;
    @(posedge I_MCLK) disable iff (I_RST)
      !finish |=> !o_DONE;
  endproperty
  a_done_only_end: assert property (p_done_only_end) else $error("Spurious done");

  property p_port_latch;
    @(posedge I_MCLK) disable iff (I_RST)
      state == ST_IDLE && i_START |=> o_PORT_OP == $past(i_PORT_OP);
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("Port op not latched");

  property p_crc_round;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && formula == bcc_pkg::FORM_CRC |=> crc == $past(crc_next);
  endproperty
  a_crc_round: assert property (p_crc_round) else $error("CRC round lost");

  property p_crc_first_in;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && crc_first && formula == bcc_pkg::FORM_CRC |->
        crc_in == (bcc_pkg::CRC_INIT ^ {8'h00, i_BYTE});
  endproperty
  a_crc_first_in: assert property (p_crc_first_in) else $error("CRC seed wrong");

  property p_crc_next_in;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && !crc_first && formula == bcc_pkg::FORM_CRC |->
        crc_in == (crc ^ {8'h00, i_BYTE});
  endproperty
  a_crc_next_in: assert property (p_crc_next_in) else $error("CRC byte fold wrong");

  property p_lrc_pair_add;
    @(posedge I_MCLK) disable iff (I_RST)
      run_byte && formula == bcc_pkg::FORM_LRC && half |=>
        sum == 16'($past(sum) + {8'h00, $past(pair_byte)}) && !half;
  endproperty
  a_lrc_pair_add: assert property (p_lrc_pair_add) else $error("LRC pair not added");

  property p_lrc_high_char;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula == bcc_pkg::FORM_LRC |=>
        (o_CHECK[15:8] inside {[8'h30:8'h39], [8'h41:8'h46]});
  endproperty
  a_lrc_high_char: assert property (p_lrc_high_char) else $error("Bad LRC char");

  property p_add_ascii_len;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula != bcc_pkg::FORM_LRC && formula != bcc_pkg::FORM_CRC && ascii_conv |=>
        (o_CHECK_LEN inside {[3'h1:3'h4]});
  endproperty
  a_add_ascii_len: assert property (p_add_ascii_len) else $error("Bad digit count");

  property p_add_raw_len;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula != bcc_pkg::FORM_LRC && formula != bcc_pkg::FORM_CRC && !ascii_conv |=>
        (o_CHECK_LEN inside {3'h1, 3'h2}) && o_CHECK[31:16] == 16'h0000;
  endproperty
  a_add_raw_len: assert property (p_add_raw_len) else $error("Bad raw length");

  property p_add_neg;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && formula == bcc_pkg::FORM_ADD && !ascii_conv && digits > 3'h2 |=>
        o_CHECK[15:0] == 16'(~$past(sum) + 16'h0001);
  endproperty
  a_add_neg: assert property (p_add_neg) else $error("Sum not negated");

  property p_start_clear;
    @(posedge I_MCLK) disable iff (I_RST)
      state == ST_IDLE && i_START |=> !o_MISMATCH;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("Mismatch not cleared");

  property p_recv_mismatch;
    @(posedge I_MCLK) disable iff (I_RST)
      finish && is_recv |=> o_MISMATCH == $past(differ);
  endproperty
  a_recv_mismatch: assert property (p_recv_mismatch) else $error("Mismatch flag wrong");
endmodule

/* sim/msg_source.sv */
/*
  Far-side model: the send/receive instruction logic streaming covered bytes.
  Assumes the bench pulses i_go for one cycle, with i_msg/i_len held steady.
*/
`timescale 1ns/1ps
module msg_source (
  input  wire logic         i_clk,
  input  wire logic         i_go,
  input  wire logic [127:0] i_msg,
  input  wire logic [4:0]   i_len,
  input  wire logic         i_slow,
  output logic              o_valid,
  output logic [7:0]        o_byte,
  output logic              o_end
);
  int k;
  initial begin
    o_valid = 0;
    o_byte  = 8'h00;
    o_end   = 0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        for (k = 0; k < i_len; k++) begin
          // Stall cycles show a toggling bus, not the last byte
          if (i_slow) begin
            o_valid <= 0;
            o_byte  <= ~o_byte;
            @(posedge i_clk);
          end
          o_valid <= 1;
          o_byte  <= i_msg[k*8+:8];
          @(posedge i_clk);
        end
        o_valid <= 0;
        o_byte  <= ~o_byte;
        o_end   <= 1;
        @(posedge i_clk);
        o_end   <= 0;
      end
    end
  end
endmodule

/* sim/tb_top.sv */
/*
  Self-checking bench for the block check calculator, all formulas and ops.
  Assumes msg_source streams bytes and o_DONE answers within 200 cycles.
*/
`timescale 1ns/1ps
module tb_top;
  logic I_MCLK = 0, I_RST = 1, i_START = 0, i_ASCII_CONV = 0, go = 0, slow = 0;
  logic [1:0] i_PORT_OP = 0, i_FORMULA = 0;
  logic [2:0] i_DIGITS = 0;
  logic [31:0] i_RX_CHECK = 0, o_CHECK;
  logic [2:0] o_CHECK_LEN;
  logic [1:0] o_PORT_OP;
  logic [127:0] msg = 0;
  logic [4:0] len = 0;
  logic valid, done_end, o_DONE, o_MISMATCH, o_BUSY;
  logic [7:0] bval;
  int seed = 26, n_mismatch = 0, num_checks = 0, cyc = 0;
  block_check_calculator i_block_check_calculator (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .i_START(i_START), .i_PORT_OP(i_PORT_OP), .i_FORMULA(i_FORMULA),
    .i_ASCII_CONV(i_ASCII_CONV), .i_DIGITS(i_DIGITS), .i_BYTE_VALID(valid),
    .i_BYTE(bval), .i_END(done_end), .i_RX_CHECK(i_RX_CHECK), .o_CHECK(o_CHECK),
    .o_CHECK_LEN(o_CHECK_LEN), .o_DONE(o_DONE), .o_MISMATCH(o_MISMATCH),
    .o_BUSY(o_BUSY), .o_PORT_OP(o_PORT_OP));
  msg_source i_msg_source (.i_clk(I_MCLK), .i_go(go), .i_msg(msg), .i_len(len),
    .i_slow(slow), .o_valid(valid), .o_byte(bval), .o_end(done_end));
  initial forever #2.5 I_MCLK = ~I_MCLK;
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge I_MCLK) begin
    cyc++;
    if (cyc >= 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] hx(input int v);
    v = v & 15;
    return (v < 10) ? 8'h30 + v : 8'h37 + v;
  endfunction
  function automatic int nib(input logic [7:0] c);
    return (c >= 8'h41) ? c - 8'h37 : c - 8'h30;
  endfunction
  task automatic run(input int f, input int op);
    logic [127:0] m;
    logic [31:0] e, rx, mk;
    logic [15:0] crc;
    int n, s, k, w, bad, asc, dg;
    m = 0; s = 0; crc = 16'hffff;
    n = 1 + ($random(seed) & 7);
    asc = $random(seed) & 1; dg = $random(seed) & 7; bad = $random(seed) & 1;
    for (k = 0; k < n; k++) m[k*8+:8] = (f == 1) ? hx($random(seed)) : $random(seed);
    if (f == 1) begin
      for (k = 0; k + 1 < n; k += 2) s += nib(m[k*8+:8]) * 16 + nib(m[k*8+8+:8]);
      s = -s; e = {hx(s >> 4), hx(s)}; w = 2;
    end else if (f == 2) begin
      for (k = 0; k < n; k++) begin
        crc ^= m[k*8+:8];
        repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
      end
      e = {crc[7:0], crc[15:8]}; w = 2;
    end else begin
      for (k = 0; k < n; k++) s += m[k*8+:8];
      s = -s; e = 0;
      if (asc) begin
        w = (dg == 0) ? 1 : (dg > 4) ? 4 : dg;
        for (k = 0; k < w; k++) e[k*8+:8] = hx(s >> (4 * k));
      end else begin
        w = (dg > 2) ? 2 : 1;
        e = s & ((w == 2) ? 32'hffff : 32'hff);
      end
    end
    mk = (w == 4) ? 32'hffffffff : (32'h1 << (8 * w)) - 1;
    // Bytes above the field are junk and must be ignored
    rx = e ^ bad ^ (~mk & $random(seed));
    @(posedge I_MCLK);
    i_START <= 1; go <= 1; msg <= m; len <= n; slow <= $random(seed);
    i_FORMULA <= f; i_PORT_OP <= op; i_ASCII_CONV <= asc; i_DIGITS <= dg;
    i_RX_CHECK <= rx;
    @(posedge I_MCLK);
    i_START <= 0; go <= 0;
    k = 0;
    do begin
      @(negedge I_MCLK);
      k++;
    end while (o_DONE !== 1'b1 && k < 200);
    check("check", e, o_CHECK);
    check("len", w, o_CHECK_LEN);
    check("mism", op[1] & bad, o_MISMATCH);
    check("op", op, o_PORT_OP);
    check("done", 1, o_DONE);
    check("busy", 0, o_BUSY);
  endtask
  initial begin
    repeat (5) @(posedge I_MCLK);
    I_RST <= 0;
    for (int f = 0; f < 4; f++)
      for (int op = 0; op < 4; op++)
        repeat (4) run(f, op);
    close_out();
  end
endmodule
